//--- core/dacc_controller.sv
// Control logic of a single-channel 10-bit converter: registers, buffer, events, interrupt
`timescale 1ns/1ps
// Summary of operation
// - New value in conversion register starts conversion
// - Config and event writes only while disabled
// - Enable bit one enables, zero disables
// - Soft reset restores all registers, disables block
// - Output pin driven only with external drive
// - Reference select picks source, internal after reset
// - Value loaded by bus write or buffer
// - Empty flag set when buffer moves to value
// - Start on empty buffer sets underrun flag
// - Flags set on events; enable set/clear
// - Request held while flag and enable set
// - All requests ORed onto one line
// - Empty event only with vacant event enable
// - Start event moves buffer when ready, resynchronized
// - Events act only with start input enabled
// - Rising edge default, falling when inverted
// - Standby keeps output only with keep bit
// - Sync busy set at once; busy write discarded
// - Reset, enable, value, buffer writes synchronized
// - Internal route independent of external drive
// - Pump automatic on low supply, forced off
// - Left align places ten bits high
// - Soft reset write discards other bits
// - Enable reads back at once, busy clears later
module dacc_controller
  import dacc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [3:0] paddr,
  input  wire logic [7:0] pwdata,
  output logic      [7:0] prdata,
  output logic            pready,
  output logic            pslverr,
  input  wire logic       startEvent,
  input  wire logic       standbySleep,
  input  wire logic       lowSupply,
  output logic      [9:0] dacCode,
  output logic            convStart,
  output logic            externalDriveOn,
  output logic            internalRouteOn,
  output logic      [1:0] referenceSelect,
  output logic            pumpOn,
  output logic            vacantEvent,
  output logic            irq
);

  // ********************************************************
  // Declarations
  // ********************************************************
  logic     [2:0]  inS1;
  logic     [2:0]  inS2;
  logic            evPrev;
  logic            evEdge;
  logic            startPending;
  logic            act;
  logic            transfer;
  logic            underrun;
  dacc_op_e        syncOp;
  dacc_op_e        next_op;
  logic     [1:0]  syncCnt;
  logic            sync_pending;
  logic            syncDone;
  logic            softReset;
  logic            clr;
  logic            wrAcc;
  logic            syncReq;
  logic            launch;
  logic     [15:0] stage;
  logic     [15:0] next_stage;
  logic            keepInStandby;
  logic            enableBit;
  logic            enabled;
  logic     [7:0]  controlConfig;
  logic     [7:0]  eventConfig;
  logic     [2:0]  intEn;
  logic     [2:0]  flags;
  logic     [2:0]  flagSet;
  logic     [2:0]  flagClr;
  logic     [15:0] value;
  logic     [15:0] buffer;
  logic            bufFull;
  logic            standbyS;
  logic            lowSupplyS;

  assign standbyS   = inS2[1];
  assign lowSupplyS = inS2[2];

  // ********************************************************
  // Bus access and synchronized operations
  // ********************************************************
  assign pready    = 1'b1;
  assign wrAcc     = psel & penable & pwrite;
  assign syncReq   = wrAcc & ((paddr == OFF_CONTROL_MAIN) | (paddr == OFF_VALUE_LO) |
                              (paddr == OFF_VALUE_HI) | (paddr == OFF_BUFFER_LO) |
                              (paddr == OFF_BUFFER_HI));
  assign sync_pending  = (syncOp != OP_NONE);
  assign launch    = syncReq & ~sync_pending;
  assign pslverr   = syncReq & sync_pending;
  assign syncDone  = sync_pending & (syncCnt == 2'h0);
  assign softReset = syncDone & (syncOp == OP_RESET);
  assign clr       = ~nrst | softReset;

  always_comb begin
    next_op    = OP_NONE;
    next_stage = value;
    unique case (paddr)
      OFF_CONTROL_MAIN: begin
        next_op = pwdata[POS_SOFT_RESET] ? OP_RESET : OP_ENABLE;
      end
      OFF_VALUE_LO: begin
        next_op    = OP_VALUE;
        next_stage = {value[15:8], pwdata};
      end
      OFF_VALUE_HI: begin
        next_op    = OP_VALUE;
        next_stage = {pwdata, value[7:0]};
      end
      OFF_BUFFER_LO: begin
        next_op    = OP_BUFFER;
        next_stage = {buffer[15:8], pwdata};
      end
      OFF_BUFFER_HI: begin
        next_op    = OP_BUFFER;
        next_stage = {pwdata, buffer[7:0]};
      end
      default: begin
        next_op    = OP_NONE;
        next_stage = value;
      end
    endcase
  end

  // Busy rises with the write itself, so software sees it on the next read
  always_ff @(posedge clk) begin
    if (clr) begin
      syncOp  <= OP_NONE;
      syncCnt <= 2'h0;
    end else if (launch) begin
      syncOp  <= next_op;
      syncCnt <= SYNC_CYCLES - 2'h1;
    end else if (syncDone) begin
      syncOp  <= OP_NONE;
    end else if (sync_pending) begin
      syncCnt <= syncCnt - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      stage <= RST_WORD;
    end else if (launch) begin
      stage <= next_stage;
    end
  end

  // ********************************************************
  // Control registers
  // ********************************************************
  always_ff @(posedge clk) begin
    if (clr) begin
      keepInStandby <= 1'b0;
      enableBit     <= 1'b0;
    end else if (launch && !pwdata[POS_SOFT_RESET] && paddr == OFF_CONTROL_MAIN) begin
      keepInStandby <= pwdata[POS_KEEP_IN_STANDBY];
      enableBit     <= pwdata[POS_ENABLE];
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      enabled <= 1'b0;
    end else if (syncDone && syncOp == OP_ENABLE) begin
      enabled <= enableBit;
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      controlConfig <= RST_BYTE;
      eventConfig   <= RST_BYTE;
    end else if (wrAcc && !enableBit) begin
      if (paddr == OFF_CONTROL_CONFIG) begin
        controlConfig <= pwdata & MASK_CONFIG;
      end
      if (paddr == OFF_EVENT_CONFIG) begin
        eventConfig <= pwdata & MASK_EVENT;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      intEn <= RST_FLAGS;
    end else if (wrAcc && paddr == OFF_IRQ_ENABLE_SET) begin
      intEn <= intEn | pwdata[2:0];
    end else if (wrAcc && paddr == OFF_IRQ_ENABLE_CLEAR) begin
      intEn <= intEn & ~pwdata[2:0];
    end
  end

  // ********************************************************
  // Value register and buffer
  // ********************************************************
  always_ff @(posedge clk) begin
    if (clr) begin
      value <= RST_WORD;
    end else if (syncDone && syncOp == OP_VALUE) begin
      value <= stage;
    end else if (transfer) begin
      value <= buffer;
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      buffer  <= RST_WORD;
      bufFull <= 1'b0;
    end else if (syncDone && syncOp == OP_BUFFER) begin
      buffer  <= stage;
      bufFull <= 1'b1;
    end else if (transfer) begin
      bufFull <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      convStart <= 1'b0;
    end else begin
      convStart <= (syncDone && syncOp == OP_VALUE) | transfer;
    end
  end

  // Code follows value and alignment every cycle; conversions are timed by the host
  always_ff @(posedge clk) begin
    if (clr) begin
      dacCode <= 10'h000;
    end else begin
      dacCode <= controlConfig[POS_LEFT_ALIGN] ? value[15:6] : value[9:0];
    end
  end

  // ********************************************************
  // Input synchronizers and start event
  // ********************************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      inS1 <= 3'h0;
      inS2 <= 3'h0;
    end else begin
      inS1 <= {lowSupply, standbySleep, startEvent};
      inS2 <= inS1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      evPrev <= 1'b0;
    end else begin
      evPrev <= inS2[0];
    end
  end

  assign evEdge = eventConfig[POS_EVENT_INVERT] ? (evPrev & ~inS2[0])
                                                : (~evPrev & inS2[0]);

  // A start during a synchronized write waits until the block is ready again
  assign act      = startPending & ~sync_pending;
  assign transfer = act & bufFull;
  assign underrun = act & ~bufFull;

  always_ff @(posedge clk) begin
    if (clr) begin
      startPending <= 1'b0;
    end else if (evEdge && enabled && eventConfig[POS_START_EVENT_IN]) begin
      startPending <= 1'b1;
    end else if (act) begin
      startPending <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      vacantEvent <= 1'b0;
    end else begin
      vacantEvent <= transfer & eventConfig[POS_VACANT_EVENT_OUT];
    end
  end

  // ********************************************************
  // Interrupt flags and request
  // ********************************************************
  assign flagSet = {syncDone, transfer, underrun};
  assign flagClr = (wrAcc && paddr == OFF_IRQ_FLAGS) ? pwdata[2:0] : 3'h0;

  // A set in the clearing cycle wins so no event is lost
  always_ff @(posedge clk) begin
    if (clr) begin
      flags <= RST_FLAGS;
    end else begin
      flags <= (flags & ~flagClr) | flagSet;
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags & intEn);
    end
  end

  // ********************************************************
  // Analog control outputs
  // ********************************************************
  always_ff @(posedge clk) begin
    if (clr) begin
      externalDriveOn <= 1'b0;
      internalRouteOn <= 1'b0;
      referenceSelect <= REF_INTERNAL;
      pumpOn          <= 1'b0;
    end else begin
      externalDriveOn <= enabled & controlConfig[POS_EXT_DRIVE_ON] &
                         ~(standbyS & ~keepInStandby);
      internalRouteOn <= enabled & controlConfig[POS_INT_ROUTE_ON];
      referenceSelect <= controlConfig[POS_REF_SELECT +: 2];
      pumpOn          <= enabled & lowSupplyS & ~controlConfig[POS_PUMP_OFF];
    end
  end

  // ********************************************************
  // Read data, captured in the setup phase
  // ********************************************************
  always_ff @(posedge clk) begin
    if (clr) begin
      prdata <= RST_BYTE;
    end else if (psel && !penable) begin
      unique case (paddr)
        OFF_CONTROL_MAIN:     prdata <= {5'h00, keepInStandby, enableBit, syncOp == OP_RESET};
        OFF_CONTROL_CONFIG:   prdata <= controlConfig;
        OFF_EVENT_CONFIG:     prdata <= eventConfig;
        OFF_IRQ_ENABLE_CLEAR: prdata <= {5'h00, intEn};
        OFF_IRQ_ENABLE_SET:   prdata <= {5'h00, intEn};
        OFF_IRQ_FLAGS:        prdata <= {5'h00, flags};
        OFF_SYNC_STATE:       prdata <= {sync_pending, 7'h00};
        OFF_VALUE_LO:         prdata <= value[7:0];
        OFF_VALUE_HI:         prdata <= value[15:8];
        OFF_BUFFER_LO:        prdata <= buffer[7:0];
        OFF_BUFFER_HI:        prdata <= buffer[15:8];
        default:              prdata <= RST_BYTE;
      endcase
    end
  end

  // ********************************************************
  // Assertions
  // ********************************************************
  sync_busy_len_a: assert property (@(posedge clk) disable iff (!nrst)
    launch |=> sync_pending [*2] ##1 !sync_pending)
    else $error("sync busy length wrong");

  busy_reject_a: assert property (@(posedge clk) disable iff (!nrst)
    (syncReq && sync_pending) |=> $stable(stage) && $stable(syncOp) || !sync_pending)
    else $error("write during busy not discarded");

  config_protect_a: assert property (@(posedge clk) disable iff (!nrst)
    (wrAcc && enableBit && !softReset) |=> $stable(controlConfig) && $stable(eventConfig))
    else $error("protected register changed while enabled");

  value_start_a: assert property (@(posedge clk) disable iff (!nrst)
    (syncDone && syncOp == OP_VALUE) |=> convStart && value == $past(stage))
    else $error("value load did not start conversion");

  buffer_move_a: assert property (@(posedge clk) disable iff (!nrst)
    transfer |=> !bufFull && flags[POS_FLAG_EMPTY] && convStart && value == $past(buffer))
    else $error("buffer transfer wrong");

  underrun_flag_a: assert property (@(posedge clk) disable iff (!nrst)
    underrun |=> flags[POS_FLAG_UNDERRUN] && !convStart)
    else $error("underrun not flagged");

  irq_combine_a: assert property (@(posedge clk) disable iff (!nrst)
    (|(flags & intEn) && !softReset) |=> irq)
    else $error("request not raised");

  soft_reset_a: assert property (@(posedge clk) disable iff (!nrst)
    softReset |=> !enableBit && !enabled && controlConfig == RST_BYTE && !bufFull)
    else $error("soft reset incomplete");

  event_gate_a: assert property (@(posedge clk) disable iff (!nrst)
    (!eventConfig[POS_START_EVENT_IN] && !startPending) |=> !startPending)
    else $error("start accepted while input disabled");

  ext_drive_a: assert property (@(posedge clk) disable iff (!nrst)
    externalDriveOn |-> $past(controlConfig[POS_EXT_DRIVE_ON]) && $past(enabled))
    else $error("output driven without external drive");

endmodule : dacc_controller

//--- core/dacc_pkg.sv
// Shared register map, field positions, reset values and timing for the converter controller
package dacc_pkg;

  // ********************************************************
  // Register offsets (byte addresses)
  // ********************************************************
  localparam logic [3:0] OFF_CONTROL_MAIN     = 4'h0;
  localparam logic [3:0] OFF_CONTROL_CONFIG   = 4'h1;
  localparam logic [3:0] OFF_EVENT_CONFIG     = 4'h2;
  localparam logic [3:0] OFF_IRQ_ENABLE_CLEAR = 4'h4;
  localparam logic [3:0] OFF_IRQ_ENABLE_SET   = 4'h5;
  localparam logic [3:0] OFF_IRQ_FLAGS        = 4'h6;
  localparam logic [3:0] OFF_SYNC_STATE       = 4'h7;
  localparam logic [3:0] OFF_VALUE_LO         = 4'h8;
  localparam logic [3:0] OFF_VALUE_HI         = 4'h9;
  localparam logic [3:0] OFF_BUFFER_LO        = 4'hc;
  localparam logic [3:0] OFF_BUFFER_HI        = 4'hd;

  // ********************************************************
  // Field positions
  // ********************************************************
  localparam int POS_SOFT_RESET       = 0;
  localparam int POS_ENABLE           = 1;
  localparam int POS_KEEP_IN_STANDBY  = 2;
  localparam int POS_EXT_DRIVE_ON     = 0;
  localparam int POS_INT_ROUTE_ON     = 1;
  localparam int POS_LEFT_ALIGN       = 2;
  localparam int POS_PUMP_OFF         = 3;
  localparam int POS_REF_SELECT       = 6;
  localparam int POS_START_EVENT_IN   = 0;
  localparam int POS_VACANT_EVENT_OUT = 1;
  localparam int POS_EVENT_INVERT     = 4;
  localparam int POS_FLAG_UNDERRUN    = 0;
  localparam int POS_FLAG_EMPTY       = 1;
  localparam int POS_FLAG_SYNC_DONE   = 2;
  localparam int POS_SYNC_PENDING     = 7;

  // ********************************************************
  // Values after reset and masks
  // ********************************************************
  localparam logic [7:0]  RST_BYTE        = 8'h00;
  localparam logic [15:0] RST_WORD        = 16'h0000;
  localparam logic [2:0]  RST_FLAGS       = 3'h0;
  localparam logic [7:0]  MASK_CONFIG     = 8'hcf;
  localparam logic [7:0]  MASK_EVENT      = 8'h13;
  localparam logic [1:0]  REF_INTERNAL    = 2'h0;
  localparam logic [1:0]  REF_SUPPLY      = 2'h1;
  localparam logic [1:0]  REF_EXTERNAL    = 2'h2;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam logic [1:0]  SYNC_CYCLES     = 2'h2;

  // Pending synchronized operation
  typedef enum logic [2:0] {
    OP_NONE   = 3'b000,
    OP_ENABLE = 3'b001,
    OP_VALUE  = 3'b011,
    OP_BUFFER = 3'b010,
    OP_RESET  = 3'b110
  } dacc_op_e;

endpackage : dacc_pkg

//--- tb/dacc_event_source.sv
// Event network stand-in that makes clean start edges on request
`timescale 1ns/1ps
module dacc_event_source (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic req,
  input  wire logic rising,
  output logic      startEvent
);
  logic [1:0] holdCnt;
  logic       target;

  // Opposite level first, held 3 cycles so the synchronizer sees it, then the target level until the next request
  always_ff @(posedge clk) begin
    if (!nrst) begin
      startEvent <= 1'b0;
      holdCnt    <= 2'h0;
      target     <= 1'b0;
    end else if (req) begin
      startEvent <= !rising;
      target     <= rising;
      holdCnt    <= 2'h3;
    end else if (holdCnt != 2'h0) begin
      holdCnt <= holdCnt - 2'h1;
      if (holdCnt == 2'h1) begin
        startEvent <= target;
      end
    end
  end
endmodule : dacc_event_source

//--- tb/dac_controller_tb_top.sv
// Self-checking bench for the converter controller
`timescale 1ns/1ps
module dac_controller_tb_top;
  import dacc_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [3:0] paddr = 4'h0;
  logic [7:0] pwdata = 8'h00, prdata, rd;
  logic pready, pslverr, err, startEvent, convStart, vacantEvent, irq, pumpOn;
  logic standbySleep = 1'b0, lowSupply = 1'b0, evReq = 1'b0, evRising = 1'b1;
  logic externalDriveOn, internalRouteOn;
  logic [9:0] dacCode;
  logic [1:0] referenceSelect;
  int fails = 0, nTests = 0, nConv = 0, nVac = 0, c, v;

  always #25 clk = ~clk;

  dacc_controller dut_u (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .startEvent(startEvent), .standbySleep(standbySleep),
    .lowSupply(lowSupply), .dacCode(dacCode), .convStart(convStart),
    .externalDriveOn(externalDriveOn), .internalRouteOn(internalRouteOn),
    .referenceSelect(referenceSelect), .pumpOn(pumpOn), .vacantEvent(vacantEvent),
    .irq(irq));
  dacc_event_source evsrc_u (.clk(clk), .nrst(nrst), .req(evReq), .rising(evRising),
    .startEvent(startEvent));

  // Pulse counters; a pulse longer than one cycle counts once per cycle
  always @(posedge clk) begin
    if (convStart === 1'b1) nConv <= nConv + 1;
    if (vacantEvent === 1'b1) nVac <= nVac + 1;
  end

  // ****************************************
  // Compare, bus and event tasks
  // ****************************************
  task automatic chkv(input logic [15:0] got, input logic [15:0] exp, input string what);
    nTests++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chkv

  task automatic chkb(input logic got, input logic exp, input string what);
    chkv({15'h0, got}, {15'h0, exp}, what);
  endtask : chkb

  // Keep holds select so a second access follows with no idle cycle
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic keep);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    rd = prdata;
    err = pslverr;
    if (!keep) begin
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 1'b0);
  endtask : wr

  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00, 1'b0);
    chkv({8'h0, rd}, {8'h0, exp}, "register read");
  endtask : rdchk

  task automatic flagchk(input logic [1:0] exp);
    bus(1'b0, OFF_IRQ_FLAGS, 8'h00, 1'b0);
    chkv({14'h0, rd[1:0]}, {14'h0, exp}, "flags");
  endtask : flagchk

  // Host waits out each sync before the next load
  task automatic wsync(input logic [3:0] a, input logic [7:0] d);
    int i;
    wr(a, d);
    for (i = 0; i < 8; i++) begin
      bus(1'b0, OFF_SYNC_STATE, 8'h00, 1'b0);
      if (rd[POS_SYNC_PENDING] === 1'b0) break;
    end
    chkb(i < 8, 1'b1, "sync finished");
  endtask : wsync

  task automatic fire(input logic rising);
    evRising <= rising;
    evReq <= 1'b1;
    @(posedge clk);
    evReq <= 1'b0;
    repeat (14) @(posedge clk);
  endtask : fire

  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    logic [3:0] offs [13] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8,
                              4'h9, 4'ha, 4'hc, 4'hd};
    foreach (offs[i]) rdchk(offs[i], 8'h00);
    chkv({14'h0, referenceSelect}, {14'h0, REF_INTERNAL}, "reference");
    chkb(pready, 1'b1, "ready");
  endtask : t_reset

  task automatic t_config;
    lowSupply <= 1'b1;
    wr(OFF_CONTROL_CONFIG, 8'h43);
    wsync(OFF_CONTROL_MAIN, 8'h02);
    rdchk(OFF_CONTROL_MAIN, 8'h02);
    chkb(externalDriveOn, 1'b1, "drive");
    chkb(internalRouteOn, 1'b1, "route");
    chkv({14'h0, referenceSelect}, 16'h1, "reference");
    chkb(pumpOn, 1'b1, "pump");
    wr(OFF_CONTROL_CONFIG, 8'h08);
    rdchk(OFF_CONTROL_CONFIG, 8'h43);
    standbySleep <= 1'b1;
    repeat (6) @(posedge clk);
    chkb(externalDriveOn, 1'b0, "standby drive");
    standbySleep <= 1'b0;
    wsync(OFF_CONTROL_MAIN, 8'h06);
    standbySleep <= 1'b1;
    repeat (6) @(posedge clk);
    chkb(externalDriveOn, 1'b1, "standby kept");
    standbySleep <= 1'b0;
    wsync(OFF_CONTROL_MAIN, 8'h00);
    chkb(externalDriveOn, 1'b0, "disabled drive");
    wr(OFF_CONTROL_CONFIG, 8'h49);
    wsync(OFF_CONTROL_MAIN, 8'h02);
    chkb(pumpOn, 1'b0, "pump forced off");
    chkb(internalRouteOn, 1'b0, "route off");
    chkb(externalDriveOn, 1'b1, "drive alone");
  endtask : t_config

  task automatic t_value;
    c = nConv;
    bus(1'b1, OFF_VALUE_LO, 8'h5a, 1'b1);
    chkb(err, 1'b0, "first write");
    bus(1'b1, OFF_VALUE_LO, 8'h77, 1'b0);
    chkb(err, 1'b1, "busy write");
    wsync(OFF_SYNC_STATE, 8'h00);
    rdchk(OFF_VALUE_LO, 8'h5a);
    chkv({6'h0, dacCode}, 16'h005a, "code");
    chkv(16'(nConv - c), 16'h1, "conversions");
    wsync(OFF_CONTROL_MAIN, 8'h00);
    wr(OFF_CONTROL_CONFIG, 8'h85);
    wsync(OFF_CONTROL_MAIN, 8'h02);
    chkv({14'h0, referenceSelect}, 16'h2, "reference");
    wsync(OFF_VALUE_HI, 8'hab);
    wsync(OFF_VALUE_LO, 8'hc0);
    chkv({6'h0, dacCode}, 16'h02af, "left code");
    chkv(16'(nConv - c), 16'h3, "conversions");
  endtask : t_value

  task automatic t_event;
    wsync(OFF_CONTROL_MAIN, 8'h00);
    wr(OFF_CONTROL_CONFIG, 8'h01);
    wr(OFF_EVENT_CONFIG, 8'h03);
    wr(OFF_IRQ_ENABLE_SET, 8'h03);
    wsync(OFF_CONTROL_MAIN, 8'h02);
    wsync(OFF_BUFFER_LO, 8'h33);
    wr(OFF_IRQ_FLAGS, 8'h07);
    c = nConv;
    v = nVac;
    fire(1'b1);
    chkv({6'h0, dacCode}, 16'h0033, "buffered code");
    chkv(16'(nConv - c), 16'h1, "conversions");
    chkv(16'(nVac - v), 16'h1, "empty events");
    flagchk(2'b10);
    chkb(irq, 1'b1, "empty irq");
    wr(OFF_IRQ_FLAGS, 8'h02);
    flagchk(2'b00);
    chkb(irq, 1'b0, "cleared irq");
    fire(1'b1);
    flagchk(2'b01);
    chkb(irq, 1'b1, "underrun irq");
    chkv(16'(nConv - c), 16'h1, "no conversion");
    wr(OFF_IRQ_FLAGS, 8'h00);
    flagchk(2'b01);
    wr(OFF_IRQ_ENABLE_CLEAR, 8'h01);
    rdchk(OFF_IRQ_ENABLE_SET, 8'h02);
    chkb(irq, 1'b0, "disabled irq");
  endtask : t_event

  task automatic t_edges;
    wsync(OFF_CONTROL_MAIN, 8'h00);
    wr(OFF_EVENT_CONFIG, 8'h11);
    wsync(OFF_CONTROL_MAIN, 8'h02);
    wsync(OFF_BUFFER_LO, 8'h44);
    c = nConv;
    fire(1'b0);
    chkv(16'(nConv - c), 16'h1, "falling start");
    wr(OFF_IRQ_FLAGS, 8'h07);
    fire(1'b1);
    chkv(16'(nConv - c), 16'h1, "rising ignored");
    flagchk(2'b00);
    wsync(OFF_CONTROL_MAIN, 8'h00);
    wr(OFF_EVENT_CONFIG, 8'h00);
    wsync(OFF_CONTROL_MAIN, 8'h02);
    wsync(OFF_BUFFER_LO, 8'h55);
    fire(1'b0);
    fire(1'b1);
    chkv(16'(nConv - c), 16'h1, "input off");
  endtask : t_edges

  task automatic t_swreset;
    wr(OFF_IRQ_ENABLE_SET, 8'h04);
    rdchk(OFF_IRQ_FLAGS, 8'h04);
    chkb(irq, 1'b1, "sync irq");
    bus(1'b1, OFF_CONTROL_MAIN, 8'h07, 1'b1);
    rdchk(OFF_CONTROL_MAIN, 8'h03);
    rdchk(OFF_SYNC_STATE, 8'h00);
    rdchk(OFF_CONTROL_MAIN, 8'h00);
    chkb(irq, 1'b0, "irq after reset");
    rdchk(OFF_CONTROL_CONFIG, 8'h00);
    rdchk(OFF_IRQ_ENABLE_SET, 8'h00);
    rdchk(OFF_BUFFER_LO, 8'h00);
    chkb(externalDriveOn, 1'b0, "drive after reset");
  endtask : t_swreset

  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset;
    t_config;
    t_value;
    t_event;
    t_edges;
    t_swreset;
    final_report;
  end

  initial begin
    #(50 * 6000);
    fails++;
    $display("unexpected at %0t: watchdog expired", $time);
    final_report;
  end
endmodule : dac_controller_tb_top
